// ### asof_regs.svh
// Register offsets, fields, reset values and timing counts of the
// serial output formatter. Included by the package and the design.
`ifndef ASOF_REGS_SVH
`define ASOF_REGS_SVH

// Register indices; byte address is four times the index
`define ASOF_IDX_TEST 8'h0d
`define ASOF_IDX_FORMAT 8'h14
`define ASOF_IDX_DRIVE 8'h15
`define ASOF_IDX_PHASE 8'h16
`define ASOF_IDX_USER1_HI 8'h19
`define ASOF_IDX_USER1_LO 8'h1a
`define ASOF_IDX_USER2_HI 8'h1b
`define ASOF_IDX_USER2_LO 8'h1c
`define ASOF_IDX_WORDLEN 8'h20
`define ASOF_IDX_STATUS 8'h21

// Field positions
`define ASOF_TEST_MODE_MSB 3
`define ASOF_TEST_PN_LONG_RST 4
`define ASOF_TEST_PN_SHORT_RST 5
`define ASOF_FMT_OFFSET_BIN 0
`define ASOF_FMT_LSB_FIRST 2
`define ASOF_DRIVE_REDUCED 0

// Reset values and the word length minimum
`define ASOF_PHASE_RESET 3'h3
`define ASOF_WORDLEN_RESET 5'h10
`define ASOF_WORDLEN_MIN 5'h0c

// Fixed words
`define ASOF_MIDSCALE 16'h8000
`define ASOF_FULL_POS 16'hffff
`define ASOF_FULL_NEG 16'h0000
`define ASOF_CHECKER1 16'haaaa
`define ASOF_CHECKER2 16'h5555
`define ASOF_SYNC_WORD 16'h00ff
`define ASOF_ONE_BIT_HIGH 16'h8000
`define ASOF_MIXED_WORD 16'ha19c
`define ASOF_SIGN_FLIP 16'h8000

// Serial frame: bits per lane per sample, phase steps per bit
`define ASOF_BITS_PER_LANE 8
`define ASOF_PHASE_STEPS 6
`define ASOF_BIT_TICKS 6

`endif

// ### asof_pkg.sv
// Types of the serial output formatter.
// Assumes asof_regs.svh sits beside it.
`include "asof_regs.svh"

package asof_pkg;

    typedef enum logic [3:0] {
        TM_OFF = 4'h0,
        TM_MIDSCALE = 4'h1,
        TM_FULL_POS = 4'h2,
        TM_FULL_NEG = 4'h3,
        TM_CHECKER = 4'h4,
        TM_PN_LONG = 4'h5,
        TM_PN_SHORT = 4'h6,
        TM_WORD_TOGGLE = 4'h7,
        TM_USER = 4'h8,
        TM_BIT_TOGGLE = 4'h9,
        TM_SYNC = 4'ha,
        TM_ONE_BIT = 4'hb,
        TM_MIXED = 4'hc
    } asof_test_e;

    typedef enum logic [0:0] {
        FR_IDLE = 1'b0,
        FR_SEND = 1'b1
    } asof_frame_e;

endpackage

// ### asof_formatter.sv
// Serial output formatter: codes two 16-bit sample streams and sends
// each over two DDR lanes with a bit clock and a frame clock.
// Assumes sample clock and samples arrive from outside clock_in's
// domain; registers are reached over an Avalon-MM slave.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`include "asof_regs.svh"

// Function
// R1: Twos complement after reset; a register bit selects offset binary.
// R2: Each channel sent on its own pair of DDR lanes.
// R3: Lane bit rate is sixteen bits times sample rate over two lanes.
// R4: Bit clock runs at four times the sample rate.
// R5: Receiver samples lanes on both bit clock edges.
// R6: Frame clock marks each word, one period per sample.
// R7: Bit clock phase moves in sixty degree steps of a bit.
// R8: Default bit clock edges sit mid bit, 180 degrees.
// R9: MSB first by default; a register bit sends LSB first.
// R10: Offset binary codes; twos complement inverts the top bit.
// R11: Standard swing after reset; a bit selects reduced swing.
// R12: Codes 1-3 send midscale and full-scale words, encoded.
// R13: Code 4 alternates AAAA and 5555, not encoded.
// R14: Code 5 sends the 23-stage sequence x^23+x^18+1, encoded.
// R15: Code 6 sends the 9-stage sequence x^9+x^5+1, encoded.
// R16: Code 7 alternates all ones and all zeros, not encoded.
// R17: Code 8 alternates two user words, not encoded.
// R18: Code 9 repeats AAAA, not encoded.
// R19: Code 10 repeats 00FF, not encoded.
// R20: Code 11 repeats 8000, not encoded.
// R21: Code 12 repeats A19C; code 0 turns tests off, default.
// R22: Any test code replaces samples; pattern still paced by sample clock.
// R23: Non-pseudorandom patterns support twelve to sixteen bit words.
// R24: Short sequence seeds all ones, sent MSB first.
// R25: Long sequence seeds all ones, bit stream inverted; the code sends the register bit uninverted.
// R26: Two-word patterns alternate per sample, frame timing unchanged.
// R27: Upper byte on first lane, lower byte on second.
module asof_formatter #(
    parameter int BIT_TICKS = `ASOF_BIT_TICKS
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Converter side
    input wire logic sample_clk_in,
    input wire logic [15:0] sample_a_in,
    input wire logic [15:0] sample_b_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Serial link
    output logic [1:0] lane_a_out,
    output logic [1:0] lane_b_out,
    output logic data_out_clock_pos_out,
    output logic data_out_clock_neg_out,
    output logic frame_out_clock_out,
    output logic reduced_swing_out
);

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_prev;
        logic [15:0] a_s1;
        logic [15:0] a_s2;
        logic [15:0] b_s1;
        logic [15:0] b_s2;
        asof_pkg::asof_test_e test_mode;
        logic offset_bin;
        logic lsb_first;
        logic reduced;
        logic [2:0] phase;
        logic [4:0] word_len;
        logic [7:0] user1_hi;
        logic [7:0] user1_lo;
        logic [7:0] user2_hi;
        logic [7:0] user2_lo;
        logic [22:0] pn_long;
        logic [8:0] pn_short;
        logic second_word;
        asof_pkg::asof_frame_e frame;
        logic [15:0] word_a;
        logic [15:0] word_b;
        logic [2:0] bit_idx;
        logic [7:0] tick;
        logic data_out_clock;
        logic dco_n;
        logic frame_out_clock;
        logic [1:0] lane_a;
        logic [1:0] lane_b;
        logic [7:0] frame_cnt;
        logic wait_n;
        logic wait_req;
        logic [31:0] rdata;
    } asof_state_s;

    asof_state_s st_reg;
    asof_state_s st_next;

    // Tick within a bit at which the bit clock toggles
    function automatic logic [7:0] phase_tick(input logic [2:0] steps);
        int t;
        t = (int'(steps) * BIT_TICKS) / `ASOF_PHASE_STEPS;
        return 8'(t);
    endfunction

    // Top bit flipped when the target coding differs from the source
    function automatic logic [15:0] encode(input logic [15:0] w,
                                           input logic src_is_offset,
                                           input logic offset_bin);
        return (src_is_offset != offset_bin) ? (w ^ `ASOF_SIGN_FLIP) : w;
    endfunction

    // Sixteen steps of the long generator; register bit taken as is, so
    // an all-ones seed gives an all-ones first word before coding
    function automatic logic [38:0] pn_long_step(input logic [22:0] s);
        logic [22:0] r;
        logic [15:0] w;
        r = s;
        w = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            w = {w[14:0], r[22]};
            r = {r[21:0], r[22] ^ r[17]};
        end
        return {r, w};
    endfunction

    // Sixteen steps of the short generator
    function automatic logic [24:0] pn_short_step(input logic [8:0] s);
        logic [8:0] r;
        logic [15:0] w;
        r = s;
        w = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            w = {w[14:0], r[8]};
            r = {r[7:0], r[8] ^ r[4]};
        end
        return {r, w};
    endfunction

    // Mask keeping the top word_len bits; all sixteen when word_len lies outside 12 to 16
    function automatic logic [15:0] len_mask(input logic [4:0] n);
        logic [4:0] k;
        k = (n < `ASOF_WORDLEN_MIN || n > 5'h10) ? 5'h10 : n;
        return 16'hffff << (5'h10 - k);
    endfunction

    logic sample_edge;
    logic [38:0] pn_long_nx;
    logic [24:0] pn_short_nx;
    logic [15:0] pat_word;
    logic pat_is_pn;
    logic [7:0] idx;
    logic addr_ok;
    logic bit_end;

    always_comb begin
        sample_edge = st_reg.sclk_s2 && !st_reg.sclk_prev;
        pn_long_nx = pn_long_step(st_reg.pn_long);
        pn_short_nx = pn_short_step(st_reg.pn_short);
        idx = {2'h0, avs_address_in[7:2]};
        addr_ok = (avs_address_in[1:0] == 2'h0);
        bit_end = (st_reg.tick == 8'(BIT_TICKS - 1));
        pat_is_pn = 1'b0;
        unique case (st_reg.test_mode)
            asof_pkg::TM_OFF:
                pat_word = 16'h0000;
            asof_pkg::TM_MIDSCALE:
                pat_word = encode(`ASOF_MIDSCALE, 1'b1,
                                  st_reg.offset_bin); // R12
            asof_pkg::TM_FULL_POS:
                pat_word = encode(`ASOF_FULL_POS, 1'b1,
                                  st_reg.offset_bin); // R12
            asof_pkg::TM_FULL_NEG:
                pat_word = encode(`ASOF_FULL_NEG, 1'b1,
                                  st_reg.offset_bin); // R12
            asof_pkg::TM_CHECKER:
                pat_word = st_reg.second_word ? `ASOF_CHECKER2
                                              : `ASOF_CHECKER1; // R13
            asof_pkg::TM_PN_LONG: begin
                pat_is_pn = 1'b1;
                // Raw generator words are offset coded
                pat_word = encode(pn_long_nx[15:0], 1'b1,
                                  st_reg.offset_bin); // R14
            end
            asof_pkg::TM_PN_SHORT: begin
                pat_is_pn = 1'b1;
                pat_word = encode(pn_short_nx[15:0], 1'b1,
                                  st_reg.offset_bin); // R15
            end
            asof_pkg::TM_WORD_TOGGLE:
                pat_word = st_reg.second_word ? 16'h0000 : 16'hffff; // R16
            asof_pkg::TM_USER:
                pat_word = st_reg.second_word
                    ? {st_reg.user2_hi, st_reg.user2_lo}
                    : {st_reg.user1_hi, st_reg.user1_lo}; // R17
            asof_pkg::TM_BIT_TOGGLE:
                pat_word = `ASOF_CHECKER1; // R18
            asof_pkg::TM_SYNC:
                pat_word = `ASOF_SYNC_WORD; // R19
            asof_pkg::TM_ONE_BIT:
                pat_word = `ASOF_ONE_BIT_HIGH; // R20
            asof_pkg::TM_MIXED:
                pat_word = `ASOF_MIXED_WORD; // R21
            default:
                pat_word = 16'h0000;
        endcase
        if (!pat_is_pn) begin
            pat_word = pat_word & len_mask(st_reg.word_len); // R23
        end
    end

    always_comb begin
        st_next = st_reg;
        // Two flops before anything reads the pins
        st_next.sclk_s1 = sample_clk_in;
        st_next.sclk_s2 = st_reg.sclk_s1;
        st_next.sclk_prev = st_reg.sclk_s2;
        st_next.a_s1 = sample_a_in;
        st_next.a_s2 = st_reg.a_s1;
        st_next.b_s1 = sample_b_in;
        st_next.b_s2 = st_reg.b_s1;

        // Bus: waitrequest drops for one cycle, write lands then
        st_next.wait_n = 1'b0;
        if ((avs_read_in || avs_write_in) && !st_reg.wait_n) begin
            st_next.wait_n = 1'b1;
            st_next.rdata = 32'h0000_0000;
            if (addr_ok) begin
                unique case (idx)
                    `ASOF_IDX_TEST:
                        st_next.rdata = {28'h0, st_reg.test_mode};
                    `ASOF_IDX_FORMAT:
                        st_next.rdata = {29'h0, st_reg.lsb_first, 1'b0,
                                         st_reg.offset_bin};
                    `ASOF_IDX_DRIVE:
                        st_next.rdata = {31'h0, st_reg.reduced};
                    `ASOF_IDX_PHASE:
                        st_next.rdata = {29'h0, st_reg.phase};
                    `ASOF_IDX_USER1_HI:
                        st_next.rdata = {24'h0, st_reg.user1_hi};
                    `ASOF_IDX_USER1_LO:
                        st_next.rdata = {24'h0, st_reg.user1_lo};
                    `ASOF_IDX_USER2_HI:
                        st_next.rdata = {24'h0, st_reg.user2_hi};
                    `ASOF_IDX_USER2_LO:
                        st_next.rdata = {24'h0, st_reg.user2_lo};
                    `ASOF_IDX_WORDLEN:
                        st_next.rdata = {27'h0, st_reg.word_len};
                    `ASOF_IDX_STATUS:
                        st_next.rdata = {22'h0, st_reg.frame,
                                         st_reg.second_word,
                                         st_reg.frame_cnt};
                    default:
                        st_next.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Word pacing from the sample clock edge
        if (sample_edge) begin
            st_next.frame = asof_pkg::FR_SEND;
            st_next.bit_idx = 3'h0;
            st_next.tick = 8'h00;
            st_next.data_out_clock = 1'b0;
            st_next.frame_cnt = st_reg.frame_cnt + 8'h01;
            if (st_reg.test_mode == asof_pkg::TM_OFF) begin
                // Core samples in offset binary
                st_next.word_a = encode(st_reg.a_s2, 1'b1,
                                        st_reg.offset_bin); // R1 R10
                st_next.word_b = encode(st_reg.b_s2, 1'b1,
                                        st_reg.offset_bin); // R1 R10
            end else begin
                st_next.word_a = pat_word; // R22
                st_next.word_b = pat_word; // R22
                st_next.second_word = !st_reg.second_word; // R26
                if (st_reg.test_mode == asof_pkg::TM_PN_LONG) begin
                    st_next.pn_long = pn_long_nx[38:16]; // R14
                end
                if (st_reg.test_mode == asof_pkg::TM_PN_SHORT) begin
                    st_next.pn_short = pn_short_nx[24:16]; // R15
                end
            end
        end else if (st_reg.frame == asof_pkg::FR_SEND) begin
            st_next.tick = bit_end ? 8'h00 : st_reg.tick + 8'h01;
            if (st_reg.tick == phase_tick(st_reg.phase)) begin
                st_next.data_out_clock = !st_reg.data_out_clock; // R4 R7 R8
            end
            if (bit_end) begin
                st_next.bit_idx = st_reg.bit_idx + 3'h1;
                if (st_reg.bit_idx == 3'(`ASOF_BITS_PER_LANE - 1)) begin
                    st_next.frame = asof_pkg::FR_IDLE; // R3
                end
            end
        end

        // Lanes: upper byte first lane, lower byte second
        if (st_next.frame == asof_pkg::FR_SEND) begin
            if (st_reg.lsb_first) begin
                st_next.lane_a = {st_next.word_a[8 + st_next.bit_idx],
                                  st_next.word_a[st_next.bit_idx]}; // R9
                st_next.lane_b = {st_next.word_b[8 + st_next.bit_idx],
                                  st_next.word_b[st_next.bit_idx]}; // R9
            end else begin
                st_next.lane_a = {st_next.word_a[15 - st_next.bit_idx],
                                  st_next.word_a[7 - st_next.bit_idx]};
                st_next.lane_b = {st_next.word_b[15 - st_next.bit_idx],
                                  st_next.word_b[7 - st_next.bit_idx]};
            end // R2 R27
            st_next.frame_out_clock = !st_next.bit_idx[2]; // R6
        end else begin
            st_next.frame_out_clock = 1'b0;
        end

        // Register writes at the edge where waitrequest is low
        if (avs_write_in && st_reg.wait_n && addr_ok) begin
            unique case (idx)
                `ASOF_IDX_TEST: begin
                    st_next.test_mode = asof_pkg::asof_test_e'(
                        avs_writedata_in[`ASOF_TEST_MODE_MSB:0]);
                    st_next.second_word = 1'b0;
                    if (avs_writedata_in[`ASOF_TEST_PN_LONG_RST]) begin
                        st_next.pn_long = '1; // R25
                    end
                    if (avs_writedata_in[`ASOF_TEST_PN_SHORT_RST]) begin
                        st_next.pn_short = '1; // R24
                    end
                end
                `ASOF_IDX_FORMAT: begin
                    st_next.offset_bin =
                        avs_writedata_in[`ASOF_FMT_OFFSET_BIN]; // R1
                    st_next.lsb_first =
                        avs_writedata_in[`ASOF_FMT_LSB_FIRST]; // R9
                end
                `ASOF_IDX_DRIVE:
                    st_next.reduced =
                        avs_writedata_in[`ASOF_DRIVE_REDUCED]; // R11
                `ASOF_IDX_PHASE:
                    st_next.phase = (avs_writedata_in[2:0] <
                        3'(`ASOF_PHASE_STEPS)) ? avs_writedata_in[2:0]
                                               : st_reg.phase; // R7
                `ASOF_IDX_USER1_HI:
                    st_next.user1_hi = avs_writedata_in[7:0];
                `ASOF_IDX_USER1_LO:
                    st_next.user1_lo = avs_writedata_in[7:0];
                `ASOF_IDX_USER2_HI:
                    st_next.user2_hi = avs_writedata_in[7:0];
                `ASOF_IDX_USER2_LO:
                    st_next.user2_lo = avs_writedata_in[7:0];
                `ASOF_IDX_WORDLEN:
                    st_next.word_len = avs_writedata_in[4:0]; // R23
                default: ;
            endcase
        end

        // Inverted copies kept in flops so every output is registered
        st_next.dco_n = !st_next.data_out_clock; // R4
        st_next.wait_req = !st_next.wait_n;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_reg <= '0;
            st_reg.test_mode <= asof_pkg::TM_OFF; // R21
            st_reg.offset_bin <= 1'b0; // R1
            st_reg.phase <= `ASOF_PHASE_RESET; // R8
            st_reg.word_len <= `ASOF_WORDLEN_RESET;
            st_reg.pn_long <= '1; // R25
            st_reg.pn_short <= '1; // R24
            st_reg.frame <= asof_pkg::FR_IDLE;
            st_reg.dco_n <= 1'b1;
            st_reg.wait_req <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_out = st_reg.rdata;
    assign avs_waitrequest_out = st_reg.wait_req;
    assign lane_a_out = st_reg.lane_a;
    assign lane_b_out = st_reg.lane_b;
    assign data_out_clock_pos_out = st_reg.data_out_clock;
    assign data_out_clock_neg_out = st_reg.dco_n;
    assign frame_out_clock_out = st_reg.frame_out_clock;
    assign reduced_swing_out = st_reg.reduced; // R11

    // Frame clock low when a frame reaches bit 4, in its second half
    property p_fco_half;
        @(posedge clock_in) disable iff (rst_in)
        (st_reg.frame == asof_pkg::FR_SEND && st_reg.bit_idx == 3'h4)
            |-> !frame_out_clock_out;
    endproperty
    a_fco_half: assert property (p_fco_half) // R6
        else $error("frame clock high in second half");

    sequence s_edge;
        st_reg.sclk_s2 && !st_reg.sclk_prev;
    endsequence

    property p_frame_start;
        @(posedge clock_in) disable iff (rst_in)
        s_edge |=> (frame_out_clock_out && st_reg.bit_idx == 3'h0
                    && !data_out_clock_pos_out);
    endproperty
    a_frame_start: assert property (p_frame_start) // R6
        else $error("frame not started on sample edge");

    property p_test_off_encode;
        @(posedge clock_in) disable iff (rst_in)
        (s_edge and st_reg.test_mode == asof_pkg::TM_OFF
         and !st_reg.offset_bin)
            |=> st_reg.word_a == ($past(st_reg.a_s2) ^ 16'h8000);
    endproperty
    a_test_off_encode: assert property (p_test_off_encode) // R1
        else $error("twos complement coding wrong");

    property p_dco_diff;
        @(posedge clock_in) disable iff (rst_in)
        data_out_clock_pos_out != data_out_clock_neg_out;
    endproperty
    a_dco_diff: assert property (p_dco_diff) // R4
        else $error("bit clock pair not complementary");

    property p_msb_first;
        @(posedge clock_in) disable iff (rst_in)
        (st_reg.frame == asof_pkg::FR_SEND && !st_reg.lsb_first
         && st_reg.tick == 8'h00)
            |-> lane_a_out == {st_reg.word_a[15 - st_reg.bit_idx],
                               st_reg.word_a[7 - st_reg.bit_idx]};
    endproperty
    a_msb_first: assert property (p_msb_first) // R27
        else $error("lane bit order wrong");

    property p_sync_word;
        @(posedge clock_in) disable iff (rst_in)
        (s_edge and st_reg.test_mode == asof_pkg::TM_SYNC
         and st_reg.word_len == 5'h10)
            |=> st_reg.word_b == 16'h00ff;
    endproperty
    a_sync_word: assert property (p_sync_word) // R19
        else $error("sync word wrong");

    property p_two_word;
        @(posedge clock_in) disable iff (rst_in)
        (s_edge and st_reg.test_mode == asof_pkg::TM_CHECKER)
            |=> st_reg.second_word != $past(st_reg.second_word);
    endproperty
    a_two_word: assert property (p_two_word) // R26
        else $error("two-word pattern did not alternate");

    property p_frame_len;
        @(posedge clock_in) disable iff (rst_in)
        (s_edge ##1 !s_edge [*8])
            |-> st_reg.frame == asof_pkg::FR_SEND;
    endproperty
    a_frame_len: assert property (p_frame_len) // R3
        else $error("frame ended early");

endmodule

// ### asof_rx_model.sv
// Receiver model: rebuilds each channel's word from its two lanes.
// Assumes BIT_TICKS of 1, so every bit stands one clock_in cycle.
module asof_rx_model (
    // Clock
    input wire logic clock_in,
    // Serial link
    input wire logic [1:0] lane_a_in,
    input wire logic [1:0] lane_b_in,
    input wire logic dco_in,
    input wire logic frame_in,
    // Received words
    output logic [15:0] word_a_out,
    output logic [15:0] word_b_out,
    output logic [3:0] tog_out,
    output logic got_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt = 4'h0;
    logic [3:0] tg = 4'h0;
    logic fr_q = 1'b0;
    logic dco_q = 1'b0;
    logic [15:0] sa, sb, na, nb;
    logic start, take;
    assign start = frame_in && !fr_q;
    assign take = start || (cnt != 4'h0 && cnt < 4'h8);
    assign na = {sa[14:8], lane_a_in[1], sa[6:0], lane_a_in[0]};
    assign nb = {sb[14:8], lane_b_in[1], sb[6:0], lane_b_in[0]};
    always @(posedge clock_in) begin
        fr_q <= frame_in;
        dco_q <= dco_in;
        got_out <= 1'b0;
        // Bit clock edges counted from one frame start to the next
        tg <= start ? 4'h0 : tg + {3'h0, dco_in != dco_q};
        if (start) begin
            tog_out <= tg;
        end
        cnt <= start ? 4'h1 : (take ? cnt + 4'h1 : 4'h0);
        if (take) begin
            sa <= na;
            sb <= nb;
        end
        if (cnt == 4'h7 && !start) begin
            word_a_out <= na;
            word_b_out <= nb;
            got_out <= 1'b1;
        end
    end
endmodule

// ### asof_formatter_tb.sv
// Bench of the serial output formatter: registers, coding, bit order
// and test words. The sample clock is stopped while cfg changes a setting.
`include "asof_regs.svh"
module asof_formatter_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic sclk = 1'b0;
    logic run = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, v;
    logic waitrq, dp, dn, frame_out_clock, swing, got;
    logic [1:0] la, lb;
    logic [15:0] wa, wb, a, b;
    logic [3:0] tg;
    logic [3:0] cd [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc};
    logic [15:0] ex [7] = '{16'h0000, 16'h7fff, 16'h8000, 16'haaaa,
        16'h00ff, 16'h8000, 16'ha19c};
    logic [3:0] tc [3] = '{4'h4, 4'h7, 4'h8};
    logic [15:0] w1 [3] = '{16'haaaa, 16'hffff, 16'h1234};
    logic [15:0] w2 [3] = '{16'h5555, 16'h0000, 16'h5678};
    logic [7:0] ub [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    asof_formatter #(.BIT_TICKS(1)) asof_formatter_i (
        .clock_in(clock_in), .rst_in(rst_in), .sample_clk_in(sclk),
        .sample_a_in(16'h1234), .sample_b_in(16'h0000),
        .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(waitrq), .lane_a_out(la), .lane_b_out(lb),
        .data_out_clock_pos_out(dp), .data_out_clock_neg_out(dn),
        .frame_out_clock_out(frame_out_clock), .reduced_swing_out(swing));
    asof_rx_model asof_rx_model_i (
        .clock_in(clock_in), .lane_a_in(la), .lane_b_in(lb),
        .dco_in(dp), .frame_in(frame_out_clock), .word_a_out(wa), .word_b_out(wb),
        .tog_out(tg), .got_out(got));
    always #5 clock_in = ~clock_in;
    // Offset keeps sample edges clear of clock_in edges
    initial #3 forever #62.5 sclk = run ? ~sclk : 1'b0;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    function automatic logic [15:0] rv(input logic [15:0] w);
        for (int i = 0; i < 16; i++) rv[i] = w[(i / 8) * 8 + 7 - i % 8];
    endfunction
    task final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] i, input logic [31:0] d);
        @(posedge clock_in);
        adr <= {i[5:0], 2'b00};
        wdat <= d;
        wr_en <= 1'b1;
        do @(posedge clock_in); while (waitrq !== 1'b0);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] i, output logic [31:0] o);
        @(posedge clock_in);
        adr <= {i[5:0], 2'b00};
        rd_en <= 1'b1;
        do @(posedge clock_in); while (waitrq !== 1'b0);
        o = rdat;
        rd_en <= 1'b0;
    endtask
    // Stopping the sample clock lets a setting start on a fresh frame
    task cfg(input logic [7:0] i, input logic [31:0] d);
        run = 1'b0;
        repeat (20) @(posedge clock_in);
        wr(i, d);
        run = 1'b1;
    endtask
    task get;
        do @(posedge clock_in); while (got !== 1'b1);
        a = wa;
        b = wb;
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(`ASOF_IDX_TEST, v); check(v, 32'h0);
        rd(`ASOF_IDX_PHASE, v); check(v, 32'h3);
        rd(`ASOF_IDX_WORDLEN, v); check(v, 32'h10);
        rd(8'h3f, v); check(v, 32'h0);
        check(swing, 1'b0);
        wr(`ASOF_IDX_PHASE, 32'h6); rd(`ASOF_IDX_PHASE, v);
        check(v, 32'h3);
        wr(`ASOF_IDX_PHASE, 32'h5); rd(`ASOF_IDX_PHASE, v);
        check(v, 32'h5);
        $display("end: reset values");
        get;
        get;
        check(a, 16'h9234);
        check(b, 16'h8000);
        check(tg, 4'h8);
        check(dn, !dp);
        cfg(`ASOF_IDX_FORMAT, 32'h1); get; check(a, 16'h1234);
        cfg(`ASOF_IDX_FORMAT, 32'h5); get; check(a, rv(16'h1234));
        cfg(`ASOF_IDX_FORMAT, 32'h0);
        cfg(`ASOF_IDX_DRIVE, 32'h1); get; check(swing, 1'b1);
        $display("end: coding and order");
        for (int i = 0; i < 7; i++) begin
            cfg(`ASOF_IDX_TEST, {28'h0, cd[i]}); get;
            check(a, ex[i]);
            check(b, ex[i]);
        end
        for (int i = 0; i < 4; i++) cfg(8'h19 + 8'(i), {24'h0, ub[i]});
        for (int i = 0; i < 3; i++) begin
            cfg(`ASOF_IDX_TEST, {28'h0, tc[i]});
            get; check(a, w1[i]);
            get; check(a, w2[i]);
        end
        $display("end: fixed words");
        cfg(`ASOF_IDX_TEST, 32'h26); get; check(a, 16'h7f83);
        get; check(a, 16'h5f17);
        cfg(`ASOF_IDX_TEST, 32'h15); get; check(a, 16'h7fff);
        get; check(a, 16'h7e00);
        cfg(`ASOF_IDX_TEST, 32'h0); get; check(a, 16'h9234);
        cfg(`ASOF_IDX_WORDLEN, 32'hc);
        cfg(`ASOF_IDX_TEST, 32'h9); get; check(a, 16'haaa0);
        $display("end: sequences and word length");
        final_report();
    end
endmodule
